// ==== shared/pot_defs.svh ====
// Constants for the quad wiper register block: offsets, field positions, reset values.
`ifndef POT_DEFS_SVH
`define POT_DEFS_SVH

`define POT_CHANNELS       4
`define POT_WIPER_MID      8'h80
`define POT_TAP_LOW        8'h00
`define POT_ZERO_BYTE      8'h00
`define POT_ACR_RESET      8'h40
`define POT_ACR_WMASK      8'h42
`define POT_ACR_SHUTDOWN_N_BIT_BIT   6
`define POT_ACR_ODRAIN_BIT 1
`define POT_ADDR_ACR       5'h10
`define POT_ADDR_WIPER_MAX 5'h03
`define POT_OP_NOP         3'h0
`define POT_OP_READ        3'h4
`define POT_OP_WRITE       3'h6
`define POT_LAST_BIT       3'h7
`define POT_FIRST_BIT      3'h1

`endif

// ==== shared/pot_pkg.sv ====
// Types and shared decode function for the quad wiper register block.
`include "pot_defs.svh"

package pot_pkg;

    typedef logic [7:0]                    byte_t;
    typedef logic [4:0]                    addr_t;
    typedef logic [`POT_CHANNELS-1:0][7:0] wiper_arr_t;

    typedef enum logic [2:0]
    {
        PH_INSTR = 3'h0,
        PH_DATA  = 3'h1,
        PH_ECHO  = 3'h2,
        PH_RDATA = 3'h3,
        PH_TAIL  = 3'h4
    } phase_t;

    // Unmapped addresses read as zero.
    function automatic byte_t read_decode(addr_t a, wiper_arr_t w, byte_t access_control);
        byte_t v;
        v = `POT_ZERO_BYTE;
        if (a <= `POT_ADDR_WIPER_MAX)
        begin
            v = w[a[1:0]];
        end
        else if (a == `POT_ADDR_ACR)
        begin
            v = access_control;
        end
        return v;
    endfunction

endpackage

// ==== shared/reg_access_if.sv ====
// Carrier between the control logic and the register bank.
interface reg_access_if;
    import pot_pkg::*;

    logic       wr_en;
    addr_t      wr_addr;
    byte_t      wr_data;
    logic       reload;
    wiper_arr_t wipers;
    byte_t      access_control;

    modport ctrl
    (
        output wr_en,
        output wr_addr,
        output wr_data,
        output reload,
        input  wipers,
        input  access_control
    );

    modport bank
    (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  reload,
        output wipers,
        output access_control
    );
endinterface

// ==== verilog/level_sync.sv ====
// Two flip-flop synchroniser for a single level.
module level_sync
#(
    parameter logic INIT = 1'b0
)
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Level
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= INIT;
            q_o     <= INIT;
        end
        else
        begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

// ==== verilog/wiper_bank.sv ====
// Four wiper position registers and the access control register.
`include "pot_defs.svh"

module wiper_bank
    import pot_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Register access
    reg_access_if.bank regs
);
    // Supply-drop reload is placed above the write so a hardware reset of the wiper wins.
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < `POT_CHANNELS; i++)
        begin
            if (rst_i || regs.reload)
            begin
                regs.wipers[i] <= `POT_WIPER_MID;
            end
            else if (regs.wr_en && regs.wr_addr == 5'(i))
            begin
                regs.wipers[i] <= regs.wr_data;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            regs.access_control <= `POT_ACR_RESET;
        end
        else if (regs.wr_en && regs.wr_addr == `POT_ADDR_ACR)
        begin
            regs.access_control <= regs.wr_data & `POT_ACR_WMASK;
        end
    end
endmodule

// ==== verilog/quad_wiper_register_spi_slave.sv ====
// Serial slave and control logic of a quad digitally controlled potentiometer.
`include "pot_defs.svh"

module quad_wiper_register_spi_slave
    import pot_pkg::*;
(
    // System clock and power-on reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Serial port
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic sdi_i,
    output logic      sdo_o,
    output logic      sdo_oe_o,
    // Supply monitor
    input  wire logic supply_low_i,
    // Analog array controls
    output wiper_arr_t wiper_tap_o,
    output logic       pot_open_o
);
    reg_access_if ra ();

    // System clock domain state.
    logic       link_clr_ff;
    logic       cs_sync;
    logic       cs_prev_ff;
    logic       armed_ff;
    logic       supply_low_sync;
    logic       wr_en_ff;
    wiper_arr_t snap_wiper_ff;
    byte_t      snap_acr_ff;
    logic       shutdown_n_bit_active;
    logic       cs_rise;
    logic       cs_fall;
    logic       taken_tog_ff;

    // Serial clock domain state.
    logic       frame_clr;
    logic       frame_start_ff;
    logic [2:0] bit_cnt_ff;
    logic [6:0] shift_ff;
    phase_t     phase_ff;
    byte_t      instr_ff;
    byte_t      wdata_ff;
    logic       wr_pend_ff;
    byte_t      rx_byte;
    byte_t      out_byte;
    logic       out_bit;
    logic       od_mode;
    logic       frame_tog_ff;

    // Instruction code and register address fields of an instruction byte.
    function automatic logic [2:0] op_code(byte_t b);
        return b[7:5];
    endfunction

    function automatic addr_t reg_addr(byte_t b);
        return b[4:0];
    endfunction

    // The serial clock only runs inside frames, so the link side is reset from
    // the system reset and from select, never from a serial clock edge.
    always_ff @(posedge clk_i)
    begin
        link_clr_ff <= rst_i;
    end

    assign frame_clr = cs_n_i | link_clr_ff;

    // Select starts as if low, so a select held low through reset never looks like a
    // falling edge; the false rise after reset is harmless as nothing is armed yet.
    level_sync #(.INIT(1'b0)) u_cs_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (cs_n_i),
        .q_o   (cs_sync)
    );

    level_sync #(.INIT(1'b0)) u_supply_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (supply_low_i),
        .q_o   (supply_low_sync)
    );

    wiper_bank u_bank
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .regs  (ra.bank)
    );

    // Select edges in the system domain.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cs_prev_ff <= 1'b0;
        end
        else
        begin
            cs_prev_ff <= cs_sync;
        end
    end

    assign cs_rise = cs_sync & ~cs_prev_ff;
    assign cs_fall = ~cs_sync & cs_prev_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            armed_ff <= 1'b0;
        end
        else if (cs_fall)
        begin
            armed_ff <= 1'b1;
        end
    end

    // Toggle value of the last frame judged at a select rise; a frame whose toggle
    // has not moved carried no serial clock and must not replay an old write.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            taken_tog_ff <= 1'b0;
        end
        else if (cs_rise)
        begin
            taken_tog_ff <= frame_tog_ff;
        end
    end

    // The link-side command stays frozen after select rises, because the serial
    // clock has stopped; two synchroniser stages give it ample settling time.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_en_ff <= 1'b0;
        end
        else
        begin
            wr_en_ff <= cs_rise & armed_ff & wr_pend_ff
                        & (frame_tog_ff != taken_tog_ff);
        end
    end

    assign ra.wr_en   = wr_en_ff;
    assign ra.wr_addr = reg_addr(instr_ff);
    assign ra.wr_data = wdata_ff;

    assign shutdown_n_bit_active = ~ra.access_control[`POT_ACR_SHUTDOWN_N_BIT_BIT];
    assign ra.reload   = shutdown_n_bit_active & supply_low_sync;

    // Register images for the link side. They track while deselected and hold
    // still during a frame, so the serial side reads words that cannot change.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            snap_wiper_ff <= {`POT_CHANNELS{`POT_WIPER_MID}};
            snap_acr_ff   <= `POT_ACR_RESET;
        end
        else if (cs_sync)
        begin
            snap_wiper_ff <= ra.wipers;
            snap_acr_ff   <= ra.access_control;
        end
    end

    // Shutdown grounds the wiper and opens the array but keeps the stored codes.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wiper_tap_o <= {`POT_CHANNELS{`POT_WIPER_MID}};
            pot_open_o  <= 1'b0;
        end
        else
        begin
            wiper_tap_o <= shutdown_n_bit_active ? {`POT_CHANNELS{`POT_TAP_LOW}} : ra.wipers;
            pot_open_o  <= shutdown_n_bit_active;
        end
    end

    // Marks the first rising serial edge of each frame.
    always_ff @(posedge sck_i or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            frame_start_ff <= 1'b1;
        end
        else
        begin
            frame_start_ff <= 1'b0;
        end
    end

    // Flips once for every frame that clocks at least one bit, so the system side
    // can tell a real frame from a select pulse with no serial clock at all.
    always_ff @(posedge sck_i or posedge link_clr_ff)
    begin
        if (link_clr_ff)
        begin
            frame_tog_ff <= 1'b0;
        end
        else if (frame_start_ff)
        begin
            frame_tog_ff <= ~frame_tog_ff;
        end
    end

    assign rx_byte = {shift_ff, sdi_i};

    // Input shifter, most significant bit first.
    always_ff @(posedge sck_i or posedge link_clr_ff)
    begin
        if (link_clr_ff)
        begin
            bit_cnt_ff <= 3'h0;
            shift_ff   <= 7'h00;
        end
        else if (frame_start_ff)
        begin
            bit_cnt_ff <= `POT_FIRST_BIT;
            shift_ff   <= {6'h00, sdi_i};
        end
        else
        begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_ff   <= rx_byte[6:0];
        end
    end

    // Byte framing: first byte is the instruction, the rest are data.
    always_ff @(posedge sck_i or posedge link_clr_ff)
    begin
        if (link_clr_ff)
        begin
            phase_ff <= PH_INSTR;
            instr_ff <= `POT_ZERO_BYTE;
        end
        else if (frame_start_ff)
        begin
            phase_ff <= PH_INSTR;
        end
        else if (bit_cnt_ff == `POT_LAST_BIT)
        begin
            unique case (phase_ff)
                PH_INSTR:
                begin
                    instr_ff <= rx_byte;
                    phase_ff <= PH_DATA;
                end
                PH_DATA:  phase_ff <= PH_ECHO;
                PH_ECHO:  phase_ff <= PH_RDATA;
                PH_RDATA: phase_ff <= PH_TAIL;
                PH_TAIL:  phase_ff <= PH_TAIL;
                default:  phase_ff <= PH_TAIL;
            endcase
        end
    end

    // Write data waits here until select rises; the last full data byte counts.
    always_ff @(posedge sck_i or posedge link_clr_ff)
    begin
        if (link_clr_ff)
        begin
            wdata_ff   <= `POT_ZERO_BYTE;
            wr_pend_ff <= 1'b0;
        end
        else if (frame_start_ff)
        begin
            wr_pend_ff <= 1'b0;
        end
        else if (bit_cnt_ff == `POT_LAST_BIT && phase_ff != PH_INSTR
                 && op_code(instr_ff) == `POT_OP_WRITE)
        begin
            wdata_ff   <= rx_byte;
            wr_pend_ff <= 1'b1;
        end
    end

    // Read answer: instruction echo, then register value; zero elsewhere.
    always_comb
    begin
        out_byte = `POT_ZERO_BYTE;
        if (op_code(instr_ff) == `POT_OP_READ)
        begin
            if (phase_ff == PH_ECHO)
            begin
                out_byte = instr_ff;
            end
            else if (phase_ff == PH_RDATA)
            begin
                out_byte = read_decode(reg_addr(instr_ff), snap_wiper_ff, snap_acr_ff);
            end
        end
    end

    assign out_bit = out_byte[3'(`POT_LAST_BIT - bit_cnt_ff)];
    assign od_mode = snap_acr_ff[`POT_ACR_ODRAIN_BIT];

    // Output stage on the falling serial edge; released while select is high.
    always_ff @(negedge sck_i or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b0;
        end
        else if (od_mode)
        begin
            sdo_o    <= 1'b0;
            sdo_oe_o <= ~out_bit;
        end
        else
        begin
            sdo_o    <= out_bit;
            sdo_oe_o <= 1'b1;
        end
    end
endmodule

// ==== verif/spi_host_model.sv ====
// Behavioural serial host that frames mode 0 transfers towards the slave.
module spi_host_model
(
    // Device output and its enable
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    // Host outputs
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // The line is pulled up whenever the device lets it go.
    wire logic line = sdo_oe_i ? sdo_i : 1'b1;
    initial
    begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end
    // Sends n bytes of tx and returns what was sampled; the clock only runs in frames.
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        cs_n_o = 1'b0;
        #300;
        for (int i = 0; i < 8 * n; i++)
        begin
            sdi_o = tx[31 - i];
            #32 sck_o = 1'b1;
            rx = {rx[30:0], line};
            #32 sck_o = 1'b0;
        end
        #300 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #2000;
    endtask
endmodule

// ==== verif/quad_wiper_register_spi_slave_monitor.sv ====
// Concurrent checks on the ports of the quad wiper register serial slave.
module quad_wiper_register_spi_slave_monitor
    import pot_pkg::*;
(
    // Clock, reset and select
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cs_n_i,
    // Outputs watched
    input wire logic       sdo_o,
    input wire logic       sdo_oe_o,
    input wire wiper_arr_t wiper_tap_o,
    input wire logic       pot_open_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_oe_off_deselect: assert property (cs_n_i && $past(cs_n_i) |-> !sdo_oe_o)
        else $error("serial output enabled while deselected");
    a_oe_lead_quiet: assert property ($fell(cs_n_i) |-> !sdo_oe_o [*2])
        else $error("serial output enabled before first clock");
    a_released_low: assert property (!sdo_oe_o |-> !sdo_o)
        else $error("serial data high while not enabled");
    a_tap_zero_shut: assert property (pot_open_o |-> wiper_tap_o == '0)
        else $error("tap not at low end in shutdown");
    a_reset_mid: assert property (disable iff (1'b0) rst_i [*3] |->
        wiper_tap_o == {4{8'h80}} && !pot_open_o)
        else $error("reset state not mid-scale");
    a_tap_hold_frame: assert property ((!cs_n_i) [*8] |->
        $stable(wiper_tap_o) && $stable(pot_open_o))
        else $error("output changed inside a frame");
    a_tap_after_desel: assert property ($changed(wiper_tap_o) |->
        cs_n_i && $past(cs_n_i, 2))
        else $error("tap changed without a frame end");
    a_open_after_desel: assert property ($changed(pot_open_o) |-> $past(cs_n_i, 3))
        else $error("shutdown changed without a frame end");
    c_shut_enter: cover property ($rose(pot_open_o));
    c_shut_leave: cover property ($fell(pot_open_o));
    c_read_drive: cover property (sdo_oe_o && sdo_o);
endmodule

bind quad_wiper_register_spi_slave quad_wiper_register_spi_slave_monitor mon_u
(
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .wiper_tap_o(wiper_tap_o), .pot_open_o(pot_open_o)
);

// ==== verif/quad_wiper_register_spi_slave_tb.sv ====
// Self-checking bench for the quad wiper register serial slave.
module quad_wiper_register_spi_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        supply_low_i = 1'b0;
    logic        sck;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe;
    logic        pot_open;
    logic [31:0] tap;
    logic [31:0] rx;
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #50 clk_i = ~clk_i;
    quad_wiper_register_spi_slave dut_u
    (
        .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .supply_low_i(supply_low_i),
        .wiper_tap_o(tap), .pot_open_o(pot_open)
    );
    spi_host_model host_u
    (
        .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_u.frame({3'h6, a, d, 16'h0000}, 2, rx);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] d);
        host_u.frame({3'h4, a, 24'h000000}, 4, rx);
        chk(rx[15:0], {3'h4, a, d});
    endtask
    // A drop lasting half a microsecond, five system clock cycles.
    task automatic drop();
        @(posedge clk_i) #1 supply_low_i = 1'b1;
        repeat (5) @(posedge clk_i);
        #1 supply_low_i = 1'b0;
    endtask
    task automatic t_reset();
        chk(tap, 32'h80808080);
        chk({pot_open, sdo_oe}, 32'h0);
        for (int i = 0; i < 4; i++)
            rd(i[4:0], 8'h80);
        rd(5'h10, 8'h40);
    endtask
    task automatic t_write();
        wr(5'h00, 8'h00);
        wr(5'h01, 8'hFF);
        wr(5'h02, 8'h55);
        host_u.frame({3'h6, 5'h03, 8'h12, 8'hA3, 8'h00}, 3, rx);
        chk(tap, 32'hA355FF00);
        rd(5'h03, 8'hA3);
    endtask
    task automatic t_refuse();
        wr(5'h05, 8'h12);
        host_u.frame({3'h0, 5'h01, 8'h33, 16'h0000}, 2, rx);
        chk(tap, 32'hA355FF00);
        rd(5'h05, 8'h00);
        wr(5'h10, 8'hFF);
        rd(5'h10, 8'h42);
        rd(5'h02, 8'h55);
        chk(sdo_oe, 32'h0);
        wr(5'h10, 8'h40);
        drop();
        chk(tap, 32'hA355FF00);
    endtask
    task automatic t_shut();
        wr(5'h10, 8'h00);
        chk(pot_open, 32'h1);
        chk(tap, 32'h0);
        rd(5'h01, 8'hFF);
        wr(5'h10, 8'h40);
        chk(tap, 32'hA355FF00);
        wr(5'h10, 8'h00);
        wr(5'h01, 8'h77);
        drop();
        // A select pulse with no clock must not replay the write made before the drop.
        host_u.frame(32'h00000000, 0, rx);
        wr(5'h10, 8'h40);
        chk(tap, 32'h80808080);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        t_reset();
        t_write();
        t_refuse();
        t_shut();
        give_verdict();
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end
endmodule
